// ===== phase_gen_pkg.sv
// Constants shared by the redundant 400 Hz phase generator
package phase_gen_pkg;
   // Clock and frequency plan
   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned MASTER_HZ   = 19_200;
   // Prescaler toggles the master square wave, so it counts half periods (rounded down)
   localparam int unsigned PRESCALE    = CLK_HZ / (2 * MASTER_HZ);
   localparam logic [10:0] PRE_LAST    = 11'(PRESCALE - 1);
   // Johnson counter lengths: a ring of n flip-flops divides by 2n
   localparam int unsigned DIV4_LEN    = 2;
   localparam int unsigned DIV10_LEN   = 5;
   localparam int unsigned DIV12_LEN   = 6;
   localparam int unsigned CYC_LEN     = 6;
   // 4.8 kHz periods without a channel A 400 Hz edge before loss is declared
   localparam logic [3:0]  LOSS_TICKS  = 4'h8;
   // Reset values
   localparam logic [5:0]  RING_RESET  = 6'h00;
   localparam logic [3:0]  LOSS_RESET  = 4'h0;
   // The 4.8 kHz output rises on this counter state going to 2'b11
   localparam logic [1:0]  DIV4_PRE_RISE = 2'h1;
   typedef enum logic [1:0] {
      SEL_A = 2'b01,
      SEL_B = 2'b10
   } sel_state_t;
endpackage

// ===== phase_gen.sv
// Redundant 400 Hz six-phase generator with reference dividers and channel selector
`timescale 1ns/1ns
module phase_gen (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Test pin that stalls channel A's oscillator
   input  wire logic       a_fail_inject,
   // Power amplifier channel drives
   output logic [5:0]      phase_p,
   output logic [5:0]      phase_n,
   // Reference square waves
   output logic            master_sq,
   output logic            ref_4k8,
   output logic            ref_1k92,
   output logic            ref_1k6,
   output logic            reg_amp_4k8,
   // Selector state
   output logic            on_chan_b
);
   function automatic logic [5:0] johnson_next(input logic [5:0] q, input int unsigned n);
      logic [5:0] nx;
      nx = 6'h00;
      for (int i = 0; i < 6; i++) begin
         if (i == 0) begin
            nx[i] = ~q[n - 1];
         end else if (i < n) begin
            nx[i] = q[i - 1];
         end
      end
      return nx;
   endfunction

   // Legal Johnson states have at most one boundary between ones and zeros
   function automatic logic ring_legal(input logic [5:0] q);
      int unsigned edges;
      edges = 0;
      for (int i = 0; i < 5; i++) begin
         if (q[i] != q[i + 1]) begin
            edges++;
         end
      end
      return edges <= 1;
   endfunction

   logic [1:0] fail_sync_reg;
   logic [1:0] run;

   // Two-stage synchroniser; only the second stage is read
   always_ff @(posedge clk) begin
      if (rst) begin
         fail_sync_reg <= 2'h0;
      end else begin
         fail_sync_reg <= {fail_sync_reg[0], a_fail_inject};
      end
   end

   assign run = {1'b1, ~fail_sync_reg[1]};

   genvar g;
   for (g = 0; g < 2; g++) begin : ch
      logic [10:0] pre_reg;
      logic        msq_reg;
      logic [5:0]  div4_reg;
      logic [5:0]  div10_reg;
      logic [5:0]  div12_reg;
      logic [5:0]  cyc_reg;
      logic        tick;
      logic        mtick;
      logic        cyc_tick;

      assign tick     = run[g] && (pre_reg == phase_gen_pkg::PRE_LAST);
      assign mtick    = tick && !msq_reg;
      assign cyc_tick = mtick && (div4_reg[1:0] == phase_gen_pkg::DIV4_PRE_RISE);

      // Crystal prescaler to the master half period
      always_ff @(posedge clk) begin
         if (rst) begin
            pre_reg <= 11'h000;
         end else if (tick) begin
            pre_reg <= 11'h000;
         end else if (run[g]) begin
            pre_reg <= pre_reg + 11'h001;
         end
      end

      // Master square wave
      always_ff @(posedge clk) begin
         if (rst) begin
            msq_reg <= 1'b0;
         end else if (tick) begin
            msq_reg <= ~msq_reg;
         end
      end

      // Reference dividers, all stepped by the master rising edge
      always_ff @(posedge clk) begin
         if (rst) begin
            div4_reg  <= phase_gen_pkg::RING_RESET;
            div10_reg <= phase_gen_pkg::RING_RESET;
            div12_reg <= phase_gen_pkg::RING_RESET;
         end else if (mtick) begin
            div4_reg  <= johnson_next(div4_reg, phase_gen_pkg::DIV4_LEN);
            div10_reg <= johnson_next(div10_reg, phase_gen_pkg::DIV10_LEN);
            div12_reg <= johnson_next(div12_reg, phase_gen_pkg::DIV12_LEN);
         end
      end

      // Cyclic register: twelve-state ring, one state per 30 degrees
      always_ff @(posedge clk) begin
         if (rst) begin
            cyc_reg <= phase_gen_pkg::RING_RESET;
         end else if (cyc_tick) begin
            cyc_reg <= johnson_next(cyc_reg, phase_gen_pkg::CYC_LEN);
         end
      end
   end

   // Channel A loss monitor, timed by channel B's 4.8 kHz clock
   logic                      a400_prev_reg;
   logic                      a_edge;
   logic [3:0]                loss_cnt_reg;
   logic                      loss;
   phase_gen_pkg::sel_state_t sel_reg;
   phase_gen_pkg::sel_state_t sel_next;

   assign a_edge = ch[0].cyc_reg[0] != a400_prev_reg;
   assign loss   = loss_cnt_reg == phase_gen_pkg::LOSS_TICKS;

   always_ff @(posedge clk) begin
      if (rst) begin
         a400_prev_reg <= 1'b0;
      end else begin
         a400_prev_reg <= ch[0].cyc_reg[0];
      end
   end

   // An edge in the same cycle as a B tick restarts the count: the edge wins
   always_ff @(posedge clk) begin
      if (rst) begin
         loss_cnt_reg <= phase_gen_pkg::LOSS_RESET;
      end else if (a_edge) begin
         loss_cnt_reg <= phase_gen_pkg::LOSS_RESET;
      end else if (ch[1].cyc_tick && !loss) begin
         loss_cnt_reg <= loss_cnt_reg + 4'h1;
      end
   end

   always_comb begin
      sel_next = sel_reg;
      case (sel_reg)
         phase_gen_pkg::SEL_A: begin
            if (loss) begin
               sel_next = phase_gen_pkg::SEL_B;
            end
         end
         phase_gen_pkg::SEL_B: begin
            sel_next = phase_gen_pkg::SEL_B;
         end
         default: begin
            sel_next = phase_gen_pkg::SEL_B;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sel_reg <= phase_gen_pkg::SEL_A;
      end else begin
         sel_reg <= sel_next;
      end
   end

   // Output buffers take the selected channel; a switch jumps straight to channel B's ring state with no phase realignment
   logic use_b;
   assign use_b = sel_reg == phase_gen_pkg::SEL_B;

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_p <= 6'h00;
         phase_n <= 6'h3F;
      end else begin
         phase_p <= use_b ? ch[1].cyc_reg : ch[0].cyc_reg;
         phase_n <= use_b ? ~ch[1].cyc_reg : ~ch[0].cyc_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         master_sq   <= 1'b0;
         ref_4k8     <= 1'b0;
         ref_1k92    <= 1'b0;
         ref_1k6     <= 1'b0;
         reg_amp_4k8 <= 1'b0;
         on_chan_b   <= 1'b0;
      end else begin
         master_sq   <= use_b ? ch[1].msq_reg : ch[0].msq_reg;
         ref_4k8     <= use_b ? ch[1].div4_reg[1] : ch[0].div4_reg[1];
         ref_1k92    <= use_b ? ch[1].div10_reg[4] : ch[0].div10_reg[4];
         ref_1k6     <= use_b ? ch[1].div12_reg[5] : ch[0].div12_reg[5];
         reg_amp_4k8 <= use_b ? ch[1].div4_reg[1] : ch[0].div4_reg[1];
         on_chan_b   <= use_b;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_complement;
      phase_n == ~phase_p;
   endproperty
   a_complement: assert property (p_complement) else $error("phase pair not complementary");

   property p_switch;
      (sel_reg == phase_gen_pkg::SEL_A && loss) |=> use_b ##1 on_chan_b;
   endproperty
   a_switch: assert property (p_switch) else $error("selector did not move to channel B");

   property p_latched;
      use_b |=> use_b;
   endproperty
   a_latched: assert property (p_latched) else $error("selector left channel B");

   property p_loss_count;
      (sel_reg == phase_gen_pkg::SEL_A && !a_edge && ch[1].cyc_tick
       && loss_cnt_reg == phase_gen_pkg::LOSS_TICKS - 4'h1) |=> ##1 use_b;
   endproperty
   a_loss_count: assert property (p_loss_count) else $error("loss not declared at limit");

   property p_cyc_hold;
      !ch[1].cyc_tick |=> $stable(ch[1].cyc_reg);
   endproperty
   a_cyc_hold: assert property (p_cyc_hold) else $error("cyclic register moved without 4.8 kHz edge");

   property p_cyc_on_4k8;
      ch[1].cyc_tick |=> $rose(ch[1].div4_reg[1]) && $changed(ch[1].cyc_reg);
   endproperty
   a_cyc_on_4k8: assert property (p_cyc_on_4k8) else $error("cycle clock not on 4.8 kHz rise");

   property p_ring_legal;
      ring_legal(ch[1].cyc_reg) && ring_legal(ch[0].cyc_reg) && ring_legal(ch[1].div12_reg);
   endproperty
   a_ring_legal: assert property (p_ring_legal) else $error("illegal ring state");

   property p_phase_step;
      $rose(ch[1].cyc_reg[1]) |-> ch[1].cyc_reg[0] && !ch[1].cyc_reg[2];
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("phases not 30 degrees apart");

   property p_sym_1k6;
      $changed(ch[1].div12_reg[5]) |-> (ch[1].div12_reg == 6'h3F || ch[1].div12_reg == 6'h00);
   endproperty
   a_sym_1k6: assert property (p_sym_1k6) else $error("1.6 kHz edge off symmetric state");

   property p_follow_b;
      use_b |=> phase_p == $past(ch[1].cyc_reg);
   endproperty
   a_follow_b: assert property (p_follow_b) else $error("outputs not from channel B");

   property p_div_on_master;
      !ch[1].mtick |=> $stable(ch[1].div10_reg);
   endproperty
   a_div_on_master: assert property (p_div_on_master) else $error("divider moved off master edge");

   c_switch: cover property (sel_reg == phase_gen_pkg::SEL_A ##1 use_b);
   c_ring_wrap: cover property ($fell(ch[1].cyc_reg[5]));
   c_a_edge: cover property (a_edge && ch[1].cyc_tick);
endmodule

// ===== phase_load_model.sv
// Load-side model: square-wave meters and a watcher on the amplifier drives
`timescale 1ns/1ns
module sq_meter (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Watched wave; last period and high time in clk cycles
   input  wire logic wave,
   output int        period,
   output int        high,
   output int        rises
);
   logic wave_reg;
   int   cnt;
   always_ff @(posedge clk) begin
      wave_reg <= wave;
      cnt <= (wave && !wave_reg) ? 1 : cnt + 1;
      if (rst) begin
         period <= 0;
         high <= 0;
         rises <= 0;
      end else if (wave && !wave_reg) begin
         period <= cnt;
         rises <= rises + 1;
      end else if (!wave && wave_reg) begin
         high <= cnt;
      end
   end
endmodule

module phase_load_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Amplifier drives and both 4.8 kHz waves
   input  wire logic [5:0] phase_p,
   input  wire logic [5:0] phase_n,
   input  wire logic       ref_4k8,
   input  wire logic       reg_amp_4k8,
   // Ring steps seen, bad steps, bad drive pairs
   output int              ring_steps,
   output int              ring_bad,
   output int              pair_bad
);
   logic [5:0] last_reg;
   logic       ref_reg;
   logic       rise;
   int         since;
   assign rise = ref_4k8 && !ref_reg;
   always_ff @(posedge clk) begin
      last_reg <= phase_p;
      ref_reg <= ref_4k8;
      since <= rise ? 0 : since + 1;
      if (rst) begin
         ring_steps <= 0;
         ring_bad <= 0;
         pair_bad <= 0;
      end else begin
         if (phase_p !== last_reg) begin
            ring_steps <= ring_steps + 1;
            // A step must be one twisted-ring shift, and only just after a 4.8 kHz rise
            if (phase_p !== {last_reg[4:0], ~last_reg[5]} || !(rise || since < 2)) begin
               ring_bad <= ring_bad + 1;
            end
         end
         if (phase_n !== ~phase_p || reg_amp_4k8 !== ref_4k8) begin
            pair_bad <= pair_bad + 1;
         end
      end
   end
endmodule

// ===== redundant_400hz_phase_generator_tb.sv
// Self-checking bench for the redundant 400 Hz phase generator
`timescale 1ns/1ns
module redundant_400hz_phase_generator_tb;
   localparam int P     = phase_gen_pkg::PRESCALE;
   // Fixed prescaler: the whole run needs about 108k cycles, so this ceiling only trips on a hang
   localparam int LIMIT = 130000;
   logic       clk           = 1'b0;
   logic       rst           = 1'b1;
   logic       a_fail_inject = 1'b0;
   logic [5:0] phase_p;
   logic [5:0] phase_n;
   logic       master_sq;
   logic       ref_4k8;
   logic       ref_1k92;
   logic       ref_1k6;
   logic       reg_amp_4k8;
   logic       on_chan_b;
   // Packed so that each meter output lands on a plain part-select
   logic [3:0][31:0] per;
   logic [3:0][31:0] hi;
   logic [3:0][31:0] ris;
   int         ring_steps;
   int         ring_bad;
   int         pair_bad;
   int         cycles     = 0;
   int         bad_count  = 0;
   int         n_compared = 0;
   logic       p0_reg;
   int         p0_age     = 0;

   always #10 clk = ~clk;

   phase_gen u_dut (.clk(clk), .rst(rst), .a_fail_inject(a_fail_inject), .phase_p(phase_p), .phase_n(phase_n),
      .master_sq(master_sq), .ref_4k8(ref_4k8), .ref_1k92(ref_1k92), .ref_1k6(ref_1k6),
      .reg_amp_4k8(reg_amp_4k8), .on_chan_b(on_chan_b));
   phase_load_model u_load (.clk(clk), .rst(rst), .phase_p(phase_p), .phase_n(phase_n), .ref_4k8(ref_4k8),
      .reg_amp_4k8(reg_amp_4k8), .ring_steps(ring_steps), .ring_bad(ring_bad), .pair_bad(pair_bad));
   sq_meter u_m0 (.clk(clk), .rst(rst), .wave(master_sq), .period(per[0]), .high(hi[0]), .rises(ris[0]));
   sq_meter u_m1 (.clk(clk), .rst(rst), .wave(ref_4k8), .period(per[1]), .high(hi[1]), .rises(ris[1]));
   sq_meter u_m2 (.clk(clk), .rst(rst), .wave(ref_1k92), .period(per[2]), .high(hi[2]), .rises(ris[2]));
   sq_meter u_m3 (.clk(clk), .rst(rst), .wave(ref_1k6), .period(per[3]), .high(hi[3]), .rises(ris[3]));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("compared=%0d mismatches=%0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         bad_count++;
         test_done;
      end
   end

   // Cycles since the last edge of phase 0; loss is timed from the last channel A edge, not from the inject
   always @(posedge clk) begin
      p0_reg <= phase_p[0];
      p0_age <= (phase_p[0] !== p0_reg) ? 0 : p0_age + 1;
   end

   task automatic test_reset;
      check(32'({phase_p, phase_n, master_sq, ref_4k8, ref_1k92, ref_1k6, reg_amp_4k8, on_chan_b}),
            32'({6'h00, 6'h3F, 6'h00}));
   endtask

   task automatic test_refs;
      int mult [4] = '{1, 4, 10, 12};
      // Two rises are needed: the first period is measured from reset
      wait (ris[3] >= 2 && ris[2] >= 2);
      @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++) begin
         check(per[i], 2 * P * mult[i]);
         check(hi[i], P * mult[i]);
      end
      check(ring_steps >= 4, 1);
      check(ring_bad, 0);
      check(on_chan_b, 0);
   endtask

   task automatic test_loss;
      int n;
      int rb;
      int rs;
      int r1;
      n = 0;
      @(posedge clk);
      a_fail_inject <= 1'b1;
      while (on_chan_b !== 1'b1 && n < 12 * 8 * P) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(n <= 8 * 8 * P + 10, 1);
      check(p0_age, 8 * 8 * P);
      repeat (5) @(posedge clk);
      rb = ring_bad;
      rs = ring_steps;
      r1 = ris[1];
      a_fail_inject <= 1'b0;
      // The rise after the switch may measure a mixed period; the one after that is pure channel B
      wait (ris[1] >= r1 + 2);
      @(posedge clk);
      #1;
      check(on_chan_b, 1);
      check(ring_bad, rb);
      check(ring_steps >= rs + 2, 1);
      check(per[1], 8 * P);
      check(pair_bad, 0);
   endtask

   initial begin
      repeat (2) @(posedge clk);
      #1;
      test_reset;
      @(posedge clk);
      rst <= 1'b0;
      test_refs;
      test_loss;
      test_done;
   end
endmodule
